// >>> logic/petq_top.v
// Function
// - Class uops tagged with code when enabled
// - Move uops tagged only with both ports
// - L1 load miss: enables 0,24,25, matrix 0
// - L2 load miss: enables 1,24,25, matrix 0
// - DTLB miss: enable 2, matrix selects kind
// - Mispredict: enables 15,16,24,25, matrix 4
// - Order replay needs partial and misaligned bits
// - Split load uses second select register
// - Split store uses first select register
// - IO, uncached, locked, returns, far untaggable
// - L2 count uses fast detection only
// - Order replay counts unaligned forwarding only
// - Stack overflow may undercount front-end tags
// - Each retirement count fixed per-thread or shared
// - Slot bits map one-to-one onto tag bits
// - Load/store marks never increment a counter
`timescale 1ns/100ps
`include "petq_map.vh"
module petq_top (
   input  wire        clk,
   input  wire        rst,
   input  wire [7:0]  s_axi_awaddr,
   input  wire        s_axi_awvalid,
   output reg         s_axi_awready,
   input  wire [31:0] s_axi_wdata,
   input  wire [3:0]  s_axi_wstrb,
   input  wire        s_axi_wvalid,
   output reg         s_axi_wready,
   output reg  [1:0]  s_axi_bresp,
   output reg         s_axi_bvalid,
   input  wire        s_axi_bready,
   input  wire [7:0]  s_axi_araddr,
   input  wire        s_axi_arvalid,
   output reg         s_axi_arready,
   output reg  [31:0] s_axi_rdata,
   output reg  [1:0]  s_axi_rresp,
   output reg         s_axi_rvalid,
   input  wire        s_axi_rready,
   input  wire        uop_valid,
   input  wire [5:0]  uop_id,
   input  wire        uop_in_class,
   input  wire        uop_port0_move,
   input  wire        uop_port2_move,
   input  wire        uop_load,
   input  wire        uop_store,
   input  wire        uop_untaggable,
   input  wire        uop_l1_miss,
   input  wire        uop_l2_fast_miss,
   input  wire        uop_dtlb_miss,
   input  wire        uop_mispred,
   input  wire        uop_fwd_unaligned,
   input  wire        uop_split_load,
   input  wire        uop_split_store,
   input  wire        ret_valid,
   input  wire [5:0]  ret_id,
   input  wire        ret_bogus,
   input  wire        ret_thread,
   output reg         fe_mark_retired_q
);
   // ==========================================================================
   // Control registers.
   reg  [31:0] tag_enable_reg_q;
   reg  [31:0] tag_matrix_reg_q;
   reg  [31:0] up_ctl_q;
   reg  [31:0] move_ctl_q;
   reg  [31:0] exec_ctl_q;
   reg  [31:0] replay_ctl_q;
   reg  [31:0] order_ctl_q;
   reg  [31:0] first_store_load_select_q;
   reg  [31:0] second_store_load_select_q;
   reg  [31:0] utype_ctl_q;
   wire [31:0] exec_cnt;
   wire [31:0] replay_cnt;

   // ==========================================================================
   // AXI4-Lite slave state.
   reg         aw_full_q;
   reg  [7:0]  awaddr_q;
   reg         w_full_q;
   reg  [31:0] wdata_q;
   reg  [3:0]  wstrb_q;
   reg         aw_full_d;
   reg         w_full_d;
   reg         do_wr;
   reg  [7:0]  wr_addr;
   reg  [31:0] wr_data;
   reg  [3:0]  wr_strb;
   reg         bvalid_d;
   reg         rvalid_d;
   reg         wr_hit;
   reg         rd_hit;
   reg  [31:0] rd_data;
   wire        ar_take;
   wire        clr_exec;
   wire        clr_replay;

   function [31:0] merge;
      input [31:0] old;
      input [31:0] data;
      input [3:0]  strb;
      integer      i;
      begin
         merge = old;
         for (i = 0; i < 4; i = i + 1) begin
            if (strb[i]) begin
               merge[i*8 +: 8] = data[i*8 +: 8];
            end
         end
      end
   endfunction

   always @* begin
      aw_full_d = aw_full_q | (s_axi_awvalid & s_axi_awready);
      w_full_d  = w_full_q | (s_axi_wvalid & s_axi_wready);
      wr_addr   = aw_full_q ? awaddr_q : s_axi_awaddr;
      wr_data   = w_full_q ? wdata_q : s_axi_wdata;
      wr_strb   = w_full_q ? wstrb_q : s_axi_wstrb;
      do_wr     = aw_full_d & w_full_d & ~s_axi_bvalid;
      bvalid_d  = (s_axi_bvalid & ~s_axi_bready) | do_wr;
      case (wr_addr)
         `PETQ_OFF_TAG_EN, `PETQ_OFF_TAG_MX, `PETQ_OFF_UP_CTL, `PETQ_OFF_MOVE_CTL,
         `PETQ_OFF_EXEC_CTL, `PETQ_OFF_REPLAY_CTL, `PETQ_OFF_ORDER_CTL,
         `PETQ_OFF_FIRST_SEL, `PETQ_OFF_SECOND_SEL, `PETQ_OFF_UTYPE_CTL,
         `PETQ_OFF_EXEC_CNT, `PETQ_OFF_REPLAY_CNT: begin
            wr_hit = 1'b1;
         end
         default: begin
            wr_hit = 1'b0;
         end
      endcase
   end

   assign ar_take    = s_axi_arvalid & s_axi_arready;
   assign clr_exec   = do_wr & (wr_addr == `PETQ_OFF_EXEC_CNT);
   assign clr_replay = do_wr & (wr_addr == `PETQ_OFF_REPLAY_CNT);

   always @* begin
      rvalid_d = (s_axi_rvalid & ~s_axi_rready) | ar_take;
      rd_hit   = 1'b1;
      case (s_axi_araddr)
         `PETQ_OFF_TAG_EN:     rd_data = tag_enable_reg_q;
         `PETQ_OFF_TAG_MX:     rd_data = tag_matrix_reg_q;
         `PETQ_OFF_UP_CTL:     rd_data = up_ctl_q;
         `PETQ_OFF_MOVE_CTL:   rd_data = move_ctl_q;
         `PETQ_OFF_EXEC_CTL:   rd_data = exec_ctl_q;
         `PETQ_OFF_REPLAY_CTL: rd_data = replay_ctl_q;
         `PETQ_OFF_ORDER_CTL:  rd_data = order_ctl_q;
         `PETQ_OFF_FIRST_SEL:  rd_data = first_store_load_select_q;
         `PETQ_OFF_SECOND_SEL: rd_data = second_store_load_select_q;
         `PETQ_OFF_UTYPE_CTL:  rd_data = utype_ctl_q;
         `PETQ_OFF_EXEC_CNT:   rd_data = exec_cnt;
         `PETQ_OFF_REPLAY_CNT: rd_data = replay_cnt;
         default: begin
            rd_data = 32'h0000_0000;
            rd_hit  = 1'b0;
         end
      endcase
   end

   // ==========================================================================
   // Bus handshake and register writes.
   always @(posedge clk) begin
      if (rst) begin
         aw_full_q                  <= 1'b0;
         awaddr_q                   <= 8'h00;
         w_full_q                   <= 1'b0;
         wdata_q                    <= 32'h0000_0000;
         wstrb_q                    <= 4'h0;
         s_axi_awready              <= 1'b1;
         s_axi_wready               <= 1'b1;
         s_axi_bvalid               <= 1'b0;
         s_axi_bresp                <= `PETQ_RESP_OKAY;
         s_axi_arready              <= 1'b1;
         s_axi_rvalid               <= 1'b0;
         s_axi_rdata                <= 32'h0000_0000;
         s_axi_rresp                <= `PETQ_RESP_OKAY;
         tag_enable_reg_q           <= `PETQ_RST_REG;
         tag_matrix_reg_q           <= `PETQ_RST_REG;
         up_ctl_q                   <= `PETQ_RST_REG;
         move_ctl_q                 <= `PETQ_RST_REG;
         exec_ctl_q                 <= `PETQ_RST_REG;
         replay_ctl_q               <= `PETQ_RST_REG;
         order_ctl_q                <= `PETQ_RST_REG;
         first_store_load_select_q  <= `PETQ_RST_REG;
         second_store_load_select_q <= `PETQ_RST_REG;
         utype_ctl_q                <= `PETQ_RST_REG;
      end else begin
         if (s_axi_awvalid & s_axi_awready) begin
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid & s_axi_wready) begin
            wdata_q <= s_axi_wdata;
            wstrb_q <= s_axi_wstrb;
         end
         aw_full_q     <= aw_full_d & ~do_wr;
         w_full_q      <= w_full_d & ~do_wr;
         s_axi_awready <= ~(aw_full_d & ~do_wr) & ~bvalid_d;
         s_axi_wready  <= ~(w_full_d & ~do_wr) & ~bvalid_d;
         s_axi_bvalid  <= bvalid_d;
         if (do_wr) begin
            s_axi_bresp <= wr_hit ? `PETQ_RESP_OKAY : `PETQ_RESP_SLVERR;
            case (wr_addr)
               `PETQ_OFF_TAG_EN:     tag_enable_reg_q <= merge(tag_enable_reg_q, wr_data, wr_strb);
               `PETQ_OFF_TAG_MX:     tag_matrix_reg_q <= merge(tag_matrix_reg_q, wr_data, wr_strb);
               `PETQ_OFF_UP_CTL:     up_ctl_q <= merge(up_ctl_q, wr_data, wr_strb);
               `PETQ_OFF_MOVE_CTL:   move_ctl_q <= merge(move_ctl_q, wr_data, wr_strb);
               `PETQ_OFF_EXEC_CTL:   exec_ctl_q <= merge(exec_ctl_q, wr_data, wr_strb);
               `PETQ_OFF_REPLAY_CTL: replay_ctl_q <= merge(replay_ctl_q, wr_data, wr_strb);
               `PETQ_OFF_ORDER_CTL:  order_ctl_q <= merge(order_ctl_q, wr_data, wr_strb);
               `PETQ_OFF_FIRST_SEL: begin
                  first_store_load_select_q <= merge(first_store_load_select_q, wr_data, wr_strb);
               end
               `PETQ_OFF_SECOND_SEL: begin
                  second_store_load_select_q <= merge(second_store_load_select_q, wr_data, wr_strb);
               end
               `PETQ_OFF_UTYPE_CTL:  utype_ctl_q <= merge(utype_ctl_q, wr_data, wr_strb);
               default: begin
               end
            endcase
         end
         s_axi_arready <= ~rvalid_d;
         s_axi_rvalid  <= rvalid_d;
         if (ar_take) begin
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_hit ? `PETQ_RESP_OKAY : `PETQ_RESP_SLVERR;
         end
      end
   end

   // ==========================================================================
   // Tag generation at dispatch.
   wire [15:0] up_mask;
   wire [15:0] mv_mask;
   wire [15:0] ex_mask;
   wire [15:0] rp_mask;
   wire [3:0]  up_code;
   wire [3:0]  mv_code;
   wire        class_tag;
   wire        move_tag;
   wire [3:0]  exec_tag;
   wire        en_global;
   wire        load_sel;
   wire        store_sel;
   wire        replay_tag;
   wire        fe_mark;

   assign up_mask = up_ctl_q[`PETQ_MASK_LSB +: 16];
   assign mv_mask = move_ctl_q[`PETQ_MASK_LSB +: 16];
   assign ex_mask = exec_ctl_q[`PETQ_MASK_LSB +: 16];
   assign rp_mask = replay_ctl_q[`PETQ_MASK_LSB +: 16];
   assign up_code = up_ctl_q[`PETQ_TAG_CODE_LSB +: 4];
   assign mv_code = move_ctl_q[`PETQ_TAG_CODE_LSB +: 4];

   // Class events are qualified per thread at the retirement counter, so no thread check here.
   assign class_tag = up_mask[`PETQ_M_ALL_CLASS] & up_ctl_q[`PETQ_MARK_EN_BIT] & uop_in_class;
   assign move_tag  = mv_mask[`PETQ_M_PORT0_MOVE] & mv_mask[`PETQ_M_PORT2_MOVE]
                      & move_ctl_q[`PETQ_MARK_EN_BIT] & (uop_port0_move | uop_port2_move);
   assign exec_tag  = (class_tag ? up_code : 4'h0) | (move_tag ? mv_code : 4'h0);

   assign en_global = tag_enable_reg_q[`PETQ_EN_GLOBAL_A] & tag_enable_reg_q[`PETQ_EN_GLOBAL_B];
   assign load_sel  = tag_matrix_reg_q[`PETQ_MX_LOAD] & uop_load;
   assign store_sel = tag_matrix_reg_q[`PETQ_MX_STORE] & uop_store;
   // Untaggable uops are filtered here once, so every replay metric drops them.
   assign replay_tag = en_global & ~uop_untaggable & (
      (tag_enable_reg_q[`PETQ_EN_L1_MISS] & load_sel & uop_l1_miss) |
      (tag_enable_reg_q[`PETQ_EN_L2_MISS] & load_sel & uop_l2_fast_miss) |
      (tag_enable_reg_q[`PETQ_EN_DTLB_MISS] & (load_sel | store_sel) & uop_dtlb_miss) |
      (tag_enable_reg_q[`PETQ_EN_BRANCH_A] & tag_enable_reg_q[`PETQ_EN_BRANCH_B]
       & tag_matrix_reg_q[`PETQ_MX_BRANCH] & uop_mispred) |
      (tag_enable_reg_q[`PETQ_EN_ORDER_REPLAY] & load_sel & uop_fwd_unaligned
       & order_ctl_q[`PETQ_MASK_LSB + `PETQ_M_PARTIAL_FWD]
       & order_ctl_q[`PETQ_MASK_LSB + `PETQ_M_MISALIGNED]) |
      (tag_enable_reg_q[`PETQ_EN_SPLIT] & load_sel & uop_split_load
       & second_store_load_select_q[`PETQ_MASK_LSB + `PETQ_M_SPLIT]) |
      (tag_enable_reg_q[`PETQ_EN_SPLIT] & store_sel & uop_split_store
       & first_store_load_select_q[`PETQ_MASK_LSB + `PETQ_M_SPLIT]));
   // Load and store marks feed only the front-end path, never a counter here.
   // Untaggable uops must not pick up a front-end mark either.
   assign fe_mark = utype_ctl_q[`PETQ_MARK_EN_BIT] & ~uop_untaggable & (
      (utype_ctl_q[`PETQ_MASK_LSB + `PETQ_M_MARK_LOADS] & uop_load) |
      (utype_ctl_q[`PETQ_MASK_LSB + `PETQ_M_MARK_STORES] & uop_store));

   // ==========================================================================
   // Tag storage from dispatch to retirement.
   reg  [3:0] exec_tag_mem [0:63];
   reg        replay_tag_mem [0:63];
   reg        fe_mark_mem [0:63];
   integer    k;

   always @(posedge clk) begin
      if (rst) begin
         for (k = 0; k < 64; k = k + 1) begin
            exec_tag_mem[k]   <= 4'h0;
            replay_tag_mem[k] <= 1'b0;
            fe_mark_mem[k]    <= 1'b0;
         end
      end else if (uop_valid) begin
         exec_tag_mem[uop_id]   <= exec_tag;
         replay_tag_mem[uop_id] <= replay_tag;
         fe_mark_mem[uop_id]    <= fe_mark;
      end
   end

   // ==========================================================================
   // Retirement qualification.
   // A tag lost on a floating-point stack fault is not recovered, so counts may fall short.
   wire [3:0] ret_exec_tag;
   wire       exec_hit;
   wire       replay_hit;

   assign ret_exec_tag = exec_tag_mem[ret_id];
   assign exec_hit = ret_valid & (ret_bogus ? |(ret_exec_tag & ex_mask[`PETQ_M_BAD_SLOT0 +: 4])
                                            : |(ret_exec_tag & ex_mask[`PETQ_M_GOOD_SLOT0 +: 4]));
   assign replay_hit = ret_valid & replay_tag_mem[ret_id] & (ret_bogus ? rp_mask[`PETQ_M_BAD_RETIRED]
                                                                     : rp_mask[`PETQ_M_GOOD_RETIRED]);

   always @(posedge clk) begin
      if (rst) begin
         fe_mark_retired_q <= 1'b0;
      end else begin
         fe_mark_retired_q <= ret_valid & ~ret_bogus & fe_mark_mem[ret_id];
      end
   end

   petq_cnt u_exec_cnt (
      .clk        (clk),
      .rst        (rst),
      .inc        (exec_hit),
      .evt_thread (ret_thread),
      .sel_thread (exec_ctl_q[`PETQ_THREAD_SEL_BIT]),
      .shared     (`PETQ_ATTR_EXEC),
      .clr        (clr_exec),
      .count_q    (exec_cnt)
   );

   petq_cnt u_replay_cnt (
      .clk        (clk),
      .rst        (rst),
      .inc        (replay_hit),
      .evt_thread (ret_thread),
      .sel_thread (replay_ctl_q[`PETQ_THREAD_SEL_BIT]),
      .shared     (`PETQ_ATTR_REPLAY),
      .clr        (clr_replay),
      .count_q    (replay_cnt)
   );
endmodule

// >>> logic/petq_map.vh
`ifndef PETQ_MAP_VH
`define PETQ_MAP_VH
// ==========================================================================
// Register byte offsets on the AXI4-Lite port.
`define PETQ_OFF_TAG_EN      8'h00
`define PETQ_OFF_TAG_MX      8'h04
`define PETQ_OFF_UP_CTL      8'h08
`define PETQ_OFF_MOVE_CTL    8'h0C
`define PETQ_OFF_EXEC_CTL    8'h10
`define PETQ_OFF_REPLAY_CTL  8'h14
`define PETQ_OFF_ORDER_CTL   8'h18
`define PETQ_OFF_FIRST_SEL   8'h1C
`define PETQ_OFF_SECOND_SEL  8'h20
`define PETQ_OFF_UTYPE_CTL   8'h24
`define PETQ_OFF_EXEC_CNT    8'h28
`define PETQ_OFF_REPLAY_CNT  8'h2C
// ==========================================================================
// Reset values.
`define PETQ_RST_REG         32'h0000_0000
// ==========================================================================
// Layout of an event select control word: mask in [24:9].
`define PETQ_MASK_LSB        9
`define PETQ_TAG_CODE_LSB    5
`define PETQ_MARK_EN_BIT     4
`define PETQ_THREAD_SEL_BIT  2
// Mask bit positions, counted from the mask field's bit 0.
`define PETQ_M_ALL_CLASS     15
`define PETQ_M_PORT0_MOVE    3
`define PETQ_M_PORT2_MOVE    4
`define PETQ_M_GOOD_SLOT0    0
`define PETQ_M_BAD_SLOT0     4
`define PETQ_M_GOOD_RETIRED  0
`define PETQ_M_BAD_RETIRED   1
`define PETQ_M_PARTIAL_FWD   4
`define PETQ_M_MISALIGNED    5
`define PETQ_M_SPLIT         1
`define PETQ_M_MARK_LOADS    1
`define PETQ_M_MARK_STORES   2
// ==========================================================================
// Tag enable and tag matrix bit positions.
`define PETQ_EN_L1_MISS      0
`define PETQ_EN_L2_MISS      1
`define PETQ_EN_DTLB_MISS    2
`define PETQ_EN_ORDER_REPLAY 9
`define PETQ_EN_SPLIT        10
`define PETQ_EN_BRANCH_A     15
`define PETQ_EN_BRANCH_B     16
`define PETQ_EN_GLOBAL_A     24
`define PETQ_EN_GLOBAL_B     25
`define PETQ_MX_LOAD         0
`define PETQ_MX_STORE        1
`define PETQ_MX_BRANCH       4
// ==========================================================================
// Thread attribute of each retirement count: 1 shared, 0 per thread.
`define PETQ_ATTR_EXEC       1'b0
`define PETQ_ATTR_REPLAY     1'b0
`define PETQ_RESP_OKAY       2'b00
`define PETQ_RESP_SLVERR     2'b10
`endif

// >>> logic/petq_cnt.v
`timescale 1ns/100ps
// ==========================================================================
// Retirement counter with logical processor qualification.
module petq_cnt (
   input  wire        clk,
   input  wire        rst,
   input  wire        inc,
   input  wire        evt_thread,
   input  wire        sel_thread,
   input  wire        shared,
   input  wire        clr,
   output reg  [31:0] count_q
);
   wire hit;
   assign hit = inc & (shared | (evt_thread == sel_thread));
   always @(posedge clk) begin
      if (rst) begin
         count_q <= 32'h0000_0000;
      end else if (hit) begin
         count_q <= count_q + 32'h0000_0001;
      end else if (clr) begin
         count_q <= 32'h0000_0000;
      end
   end
endmodule

// >>> testbench/petq_chk.sv
`timescale 1ns/100ps
// ==========================================================================
// Port checks on the register bus and the retirement mark.
module petq_chk (
   input wire        clk,
   input wire        rst,
   input wire        s_axi_awvalid,
   input wire        s_axi_awready,
   input wire        s_axi_wvalid,
   input wire        s_axi_wready,
   input wire [1:0]  s_axi_bresp,
   input wire        s_axi_bvalid,
   input wire        s_axi_bready,
   input wire [7:0]  s_axi_araddr,
   input wire        s_axi_arvalid,
   input wire        s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire [1:0]  s_axi_rresp,
   input wire        s_axi_rvalid,
   input wire        s_axi_rready,
   input wire        uop_valid,
   input wire [5:0]  uop_id,
   input wire        uop_load,
   input wire        uop_store,
   input wire        uop_untaggable,
   input wire        ret_valid,
   input wire [5:0]  ret_id,
   input wire        ret_bogus,
   input wire        fe_mark_retired_q
);
   reg [63:0] untag_q;
   reg [63:0] kind_q;
   reg        mark_ok_q;
   reg        ar_bad_q;
   // ==========================================================================
   // Shadow slot table.
   // Updated by non-blocking assignment, so a retire on the dispatch edge sees the old entry, as the design does.
   always @(posedge clk) begin
      if (rst) begin
         untag_q   <= 64'h0;
         kind_q    <= 64'h0;
         mark_ok_q <= 1'h0;
         ar_bad_q  <= 1'h0;
      end else begin
         if (uop_valid) begin
            untag_q[uop_id] <= uop_untaggable;
            kind_q[uop_id]  <= uop_load | uop_store;
         end
         mark_ok_q <= ret_valid & ~ret_bogus & ~untag_q[ret_id] & kind_q[ret_id];
         if (s_axi_arvalid && s_axi_arready)
            ar_bad_q <= (s_axi_araddr > 8'h2C) || (s_axi_araddr[1:0] != 2'h0);
      end
   end
   // ==========================================================================
   // Assertions.
   default clocking dcb @(posedge clk);
   endclocking
   default disable iff (rst);
   sequence aw_w_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence ar_taken;
      s_axi_arvalid && s_axi_arready;
   endsequence
   AST_WRITE_ANSWER: assert property (aw_w_taken |=> s_axi_bvalid && !s_axi_awready && !s_axi_wready)
      else $error("write answer missing");
   AST_WRITE_HOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write answer dropped");
   AST_WRITE_RELEASE: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write channel not released");
   AST_READ_ANSWER: assert property (ar_taken |=> s_axi_rvalid && !s_axi_arready)
      else $error("read answer missing");
   AST_READ_HOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable({s_axi_rresp, s_axi_rdata}))
      else $error("read answer dropped");
   AST_READ_RESP: assert property (s_axi_rvalid |-> s_axi_rresp == (ar_bad_q ? 2'h2 : 2'h0))
      else $error("read response code wrong");
   AST_MARK_CAUSE: assert property (fe_mark_retired_q |-> $past(ret_valid) && !$past(ret_bogus))
      else $error("mark without good retirement");
   AST_MARK_TAGGABLE: assert property (fe_mark_retired_q |-> mark_ok_q)
      else $error("mark on untaggable or unmarked slot");
endmodule
bind petq_top petq_chk u_chk (
   .clk(clk), .rst(rst), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
   .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .uop_valid(uop_valid), .uop_id(uop_id), .uop_load(uop_load), .uop_store(uop_store),
   .uop_untaggable(uop_untaggable), .ret_valid(ret_valid), .ret_id(ret_id), .ret_bogus(ret_bogus),
   .fe_mark_retired_q(fe_mark_retired_q));

// >>> testbench/perf_event_tag_qualify_tb.sv
`timescale 1ns/100ps
// ==========================================================================
// Bench for the tagging block.
module perf_event_tag_qualify_tb;
   reg         clk, rst, awv, wv, bre, arv, rre, uv, rtv, rtb, rtt;
   reg  [7:0]  awa, ara, tmx, xa;
   reg  [31:0] wd, rn, ten, xv;
   reg  [3:0]  ws;
   reg  [5:0]  uid, rid;
   reg  [12:0] uq, tq;
   wire        awr, wrdy, bv, arr, rv, fe;
   wire [1:0]  br, rr;
   wire [31:0] rd;
   reg  [33:0] e_r;
   reg  [1:0]  e_b;
   reg  [33:0] exp_r[$];
   reg  [1:0]  exp_b[$];
   integer     mismatches = 0, samples_checked = 0, marks_seen = 0, cyc = 0, i;
   petq_top uut (
      .clk(clk), .rst(rst), .s_axi_awaddr(awa), .s_axi_awvalid(awv), .s_axi_awready(awr),
      .s_axi_wdata(wd), .s_axi_wstrb(ws), .s_axi_wvalid(wv), .s_axi_wready(wrdy), .s_axi_bresp(br),
      .s_axi_bvalid(bv), .s_axi_bready(bre), .s_axi_araddr(ara), .s_axi_arvalid(arv),
      .s_axi_arready(arr), .s_axi_rdata(rd), .s_axi_rresp(rr), .s_axi_rvalid(rv), .s_axi_rready(rre),
      .uop_valid(uv), .uop_id(uid), .uop_in_class(uq[12]), .uop_port0_move(uq[11]),
      .uop_port2_move(uq[10]), .uop_load(uq[9]), .uop_store(uq[8]), .uop_untaggable(uq[7]),
      .uop_l1_miss(uq[6]), .uop_l2_fast_miss(uq[5]), .uop_dtlb_miss(uq[4]), .uop_mispred(uq[3]),
      .uop_fwd_unaligned(uq[2]), .uop_split_load(uq[1]), .uop_split_store(uq[0]), .ret_valid(rtv),
      .ret_id(rid), .ret_bogus(rtb), .ret_thread(rtt), .fe_mark_retired_q(fe));
   initial begin
      clk = 1'h0;
      forever #5 clk = ~clk;
   end
   // ==========================================================================
   // Tasks.
   task report_and_stop;
      begin
         if (mismatches == 0 && samples_checked > 0)
            $display("[ PASS ]");
         else
            $display("[ FAIL ]");
         $finish;
      end
   endtask
   task chk(input string n, input [33:0] e, input [33:0] s);
      begin
         samples_checked = samples_checked + 1;
         if (s !== e) begin
            mismatches = mismatches + 1;
            $display("[FAIL] %s expected %h seen %h", n, e, s);
         end
      end
   endtask
   // A spare edge after each transfer keeps the next call from assigning a signal twice at one edge.
   task wrx(input [7:0] a, input [31:0] d, input [3:0] s, input [1:0] e);
      begin
         exp_b.push_back(e);
         {awa, wd, ws} <= {a, d, s};
         {awv, wv, bre} <= 3'h7;
         do begin
            @(posedge clk);
            if (awv && awr === 1'h1)
               awv <= 1'h0;
            if (wv && wrdy === 1'h1)
               wv <= 1'h0;
            if (bre && bv === 1'h1)
               bre <= 1'h0;
         end while (awv || wv || bre);
         @(posedge clk);
      end
   endtask
   task wr(input [7:0] a, input [31:0] d);
      wrx(a, d, 4'hF, 2'h0);
   endtask
   task rd32(input [7:0] a, input [33:0] e);
      begin
         exp_r.push_back(e);
         ara <= a;
         {arv, rre} <= 2'h3;
         do begin
            @(posedge clk);
            if (arv && arr === 1'h1)
               arv <= 1'h0;
            if (rre && rv === 1'h1)
               rre <= 1'h0;
         end while (arv || rre);
         @(posedge clk);
      end
   endtask
   task pass(input [12:0] q, input b, input t);
      begin
         rn = $urandom;
         {uid, uq, uv} <= {rn[5:0], q, 1'h1};
         @(posedge clk);
         uv <= 1'h0;
         {rid, rtb, rtt, rtv} <= {rn[5:0], b, t, 1'h1};
         @(posedge clk);
         rtv <= 1'h0;
         @(posedge clk);
      end
   endtask
   // ==========================================================================
   // Monitor and timeout.
   always @(posedge clk) begin
      if (fe === 1'h1)
         marks_seen = marks_seen + 1;
      if (rv === 1'h1 && rre) begin
         e_r = exp_r.pop_front();
         chk("read", e_r, {rr, rd});
      end
      if (bv === 1'h1 && bre) begin
         e_b = exp_b.pop_front();
         chk("write resp", {32'h0, e_b}, {32'h0, br});
      end
      cyc = cyc + 1;
      if (cyc == 8000) begin
         mismatches = mismatches + 1;
         report_and_stop;
      end
   end
   // ==========================================================================
   // Main sequence.
   initial begin
      {awa, ara, wd, ws, awv, wv, bre, arv, rre} = 57'h0;
      {uv, rtv, rtb, rtt, uid, rid, uq} = 29'h0;
      rst = 1'h1;
      void'($urandom(43));
      repeat (5) @(posedge clk);
      rst <= 1'h0;
      @(posedge clk);
      for (i = 0; i < 12; i = i + 1)
         rd32(8'(i * 4), 34'h0);
      rd32(8'h30, 34'h2_0000_0000);
      wrx(8'h30, 32'hFFFF_FFFF, 4'hF, 2'h2);
      for (i = 0; i < 10; i = i + 1) begin
         rn = $urandom;
         wr(8'(i * 4), rn);
         rd32(8'(i * 4), {2'h0, rn});
         wrx(8'(i * 4), 32'h0, 4'h3, 2'h0);
         rd32(8'(i * 4), {2'h0, rn[31:16], 16'h0});
         wr(8'(i * 4), 32'h0);
      end
      wr(8'h08, 32'h0100_0030);
      wr(8'h10, 32'h0000_0200);
      pass(13'h1000, 1'h0, 1'h0);
      pass(13'h1000, 1'h1, 1'h0);
      pass(13'h1000, 1'h0, 1'h1);
      rd32(8'h28, 34'h1);
      wr(8'h10, 32'h0000_0204);
      pass(13'h1000, 1'h0, 1'h1);
      wr(8'h08, 32'h0100_0050);
      pass(13'h1000, 1'h0, 1'h1);
      rd32(8'h28, 34'h2);
      wr(8'h08, 32'h0);
      wr(8'h0C, 32'h0000_3030);
      pass(13'h0800, 1'h0, 1'h1);
      wr(8'h0C, 32'h0000_1030);
      pass(13'h0800, 1'h0, 1'h1);
      rd32(8'h28, 34'h3);
      wr(8'h14, 32'h0000_0200);
      for (i = 0; i < 9; i = i + 1) begin
         case (i)
            0: {ten, tmx, tq, xa, xv} = {32'h0300_0001, 8'h01, 13'h0240, 8'h18, 32'h0};
            1: {ten, tmx, tq, xa, xv} = {32'h0300_0002, 8'h01, 13'h0220, 8'h18, 32'h0};
            2: {ten, tmx, tq, xa, xv} = {32'h0300_0004, 8'h01, 13'h0210, 8'h18, 32'h0};
            3: {ten, tmx, tq, xa, xv} = {32'h0300_0004, 8'h02, 13'h0110, 8'h18, 32'h0};
            4: {ten, tmx, tq, xa, xv} = {32'h0300_0004, 8'h03, 13'h0110, 8'h18, 32'h0};
            5: {ten, tmx, tq, xa, xv} = {32'h0301_8000, 8'h10, 13'h0008, 8'h18, 32'h0};
            6: {ten, tmx, tq, xa, xv} = {32'h0300_0200, 8'h01, 13'h0204, 8'h18, 32'h0000_6000};
            7: {ten, tmx, tq, xa, xv} = {32'h0300_0400, 8'h01, 13'h0202, 8'h20, 32'h0000_0400};
            default: {ten, tmx, tq, xa, xv} = {32'h0300_0400, 8'h02, 13'h0101, 8'h1C, 32'h0000_0400};
         endcase
         wr(xa, xv);
         wr(8'h04, {24'h0, tmx});
         wr(8'h00, ten & 32'hFDFF_FFFF);
         pass(tq, 1'h0, 1'h0);
         wr(8'h00, ten);
         pass(tq | 13'h0080, 1'h0, 1'h0);
         pass(tq, 1'h1, 1'h0);
         pass(tq, 1'h0, 1'h0);
         rd32(8'h2C, 34'h1);
         wr(8'h2C, 32'h0);
      end
      wr(8'h24, 32'h0000_0410);
      pass(13'h0200, 1'h0, 1'h0);
      pass(13'h0000, 1'h0, 1'h0);
      pass(13'h0280, 1'h0, 1'h0);
      rd32(8'h2C, 34'h0);
      rd32(8'h28, 34'h3);
      chk("marks", 34'h1, {2'h0, marks_seen});
      report_and_stop;
   end
endmodule
